// file: bench/atp_assertions.sv
// checker: port-level timing of the trajectory profiler
`timescale 1ns/1ps
module atp_assertions #(parameter int AXES = 4, parameter int POS_W = 32) (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  sample_tick,
    input wire logic [3:0]            addr,
    input wire logic [31:0]           wdata,
    input wire logic                  wr,
    input wire logic                  rd,
    input wire logic [31:0]           rdata,
    input wire logic [AXES*POS_W-1:0] actual_position,
    input wire logic [AXES*POS_W-1:0] commanded_position,
    input wire logic [AXES-1:0]       wait_profiler_done,
    input wire logic [AXES-1:0]       wait_in_position
);
    logic signed [POS_W-1:0] gap;
    assign gap = actual_position[POS_W-1:0] - commanded_position[POS_W-1:0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0) else $error("rdata not idle");
    a_pos_tick_paced: assert property (!$past(sample_tick) && !$past(wr) |-> $stable(commanded_position))
        else $error("position moved off tick");
    a_inpos_needs_done: assert property (wait_in_position[0] |-> wait_profiler_done[0])
        else $error("in position while busy");
    a_inpos_tol: assert property (wait_in_position[0] |-> gap <= 2 && gap >= -2) else $error("tolerance");
    a_inpos_when_met: assert property (wait_profiler_done[0] && gap == 0 |-> wait_in_position[0])
        else $error("in position missing");
    a_done_on_tick: assert property ($rose(wait_profiler_done[0]) |-> $past(sample_tick))
        else $error("done off tick");
    a_start_by_cmd: assert property ($fell(wait_profiler_done[0]) |-> $past(wr) || $past(wr, 2))
        else $error("start without command");
    a_done_stable: assert property (!$past(sample_tick) && !$past(wr) && !$past(wr, 2) |-> $stable(wait_profiler_done))
        else $error("done changed off tick");
endmodule : atp_assertions
bind axis_trajectory_profiler atp_assertions #(.AXES(AXES), .POS_W(POS_W)) i_chk (.clk(clk), .rst_n(rst_n),
    .sample_tick(sample_tick), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .actual_position(actual_position), .commanded_position(commanded_position),
    .wait_profiler_done(wait_profiler_done), .wait_in_position(wait_in_position));

// file: bench/atp_servo_model.sv
// partner: servo whose measured position trails the command
`timescale 1ns/1ps
module atp_servo_model #(parameter int W = 128) (
    // clock and reset
    input wire logic         clk,
    input wire logic         rst_n,
    // servo side
    input wire logic [W-1:0] cmd,
    output logic     [W-1:0] act
);
    // one-cycle lag, so with smoothing off in-position is seen only after the command settles
    always_ff @(posedge clk) act <= rst_n ? cmd : '0;
endmodule : atp_servo_model

// file: bench/testbench.sv
// testbench: command-port scenarios for the trajectory profiler
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, rst_n = 1'b0, tick = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [3:0] addr = 4'h0, done, inpos;
    logic [31:0] wdata = 32'h0, rdata, got, p;
    logic [127:0] act, cmd;
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    axis_trajectory_profiler i_dut (.clk(clk), .rst_n(rst_n), .sample_tick(tick), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .actual_position(act), .commanded_position(cmd),
        .wait_profiler_done(done), .wait_in_position(inpos));
    atp_servo_model i_servo (.clk(clk), .rst_n(rst_n), .cmd(cmd), .act(act));
    initial forever #2.5 clk = ~clk;
    task automatic tally_and_finish();
        $display("checked %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        cyc <= cyc + 1;
        tick <= (cyc % 4 == 0);
        if (cyc == 30000) begin
            error_cnt = error_cnt + 1;
            tally_and_finish();
        end
    end
    task automatic chk(string name, logic [31:0] exp, logic [31:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic put(logic [3:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : put
    task automatic get(logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 got = rdata;
    endtask : get
    // the first edges after a start may still show the old idle flag
    task automatic wait_idle();
        repeat (3) @(negedge clk);
        while (done[0] !== 1'b1) @(negedge clk);
    endtask : wait_idle
    task automatic s_move();
        get(atp_pkg::ADDR_STATUS);
        chk("status idle", 32'h6, got);
        put(atp_pkg::ADDR_AXIS_SEL, 32'h1);
        put(atp_pkg::ADDR_TARGET_ABS, 32'h80);
        put(atp_pkg::ADDR_AXIS_SEL, 32'h0);
        put(atp_pkg::ADDR_TARGET_ABS, 32'h100);
        put(atp_pkg::ADDR_BEGIN, 32'h0);
        get(atp_pkg::ADDR_DEST);
        chk("dest moving", 32'h100, got);
        put(atp_pkg::ADDR_DECEL, 32'h200);
        put(atp_pkg::ADDR_TARGET_ABS, 32'h0);
        get(atp_pkg::ADDR_STATUS);
        chk("status reject", 32'h9, got);
        wait_idle();
        chk("axis0 arrive", 32'h100, cmd[31:0]);
        chk("axis1 arrive", 32'h80, cmd[63:32]);
        get(atp_pkg::ADDR_STATUS);
        chk("status done", 32'h6, got);
        chk("in position pin", 32'h1, {31'h0, inpos[0]});
        put(atp_pkg::ADDR_INCR, 32'h40);
        wait_idle();
        chk("incr idle", 32'h140, cmd[31:0]);
        put(atp_pkg::ADDR_TARGET_REL, 32'hffffffc0);
        put(atp_pkg::ADDR_BEGIN, 32'h1);
        wait_idle();
        chk("relative", 32'h100, cmd[31:0]);
    endtask : s_move
    task automatic s_halt_jog();
        put(atp_pkg::ADDR_TARGET_ABS, 32'h10000);
        put(atp_pkg::ADDR_BEGIN, 32'h1);
        repeat (200) @(negedge clk);
        p = cmd[31:0];
        put(atp_pkg::ADDR_HALT, 32'h1);
        wait_idle();
        chk("halt short", 32'h1, {31'h0, cmd[31:0] < 32'h10000});
        chk("halt ramps", 32'h1, {31'h0, cmd[31:0] > p + 32'h40});
        put(atp_pkg::ADDR_MODE, 32'h1);
        put(atp_pkg::ADDR_JOG, 32'h00fff800);
        put(atp_pkg::ADDR_BEGIN, 32'h1);
        // long enough that a whole 256-tick window lies in steady jog
        repeat (2400) @(negedge clk);
        get(atp_pkg::ADDR_AVG_VEL);
        chk("avg velocity", 32'hfffffff8, got);
        p = cmd[31:0];
        repeat (40) @(negedge clk);
        chk("jog reverse", 32'h1, {31'h0, $signed(cmd[31:0]) < $signed(p)});
        put(atp_pkg::ADDR_HALT, 32'h1);
        wait_idle();
        p = cmd[31:0];
        put(atp_pkg::ADDR_INCR, 32'h100);
        repeat (8) @(negedge clk);
        chk("jog nudge", p + 32'h100, cmd[31:0]);
        put(atp_pkg::ADDR_SMOOTH, 32'h2);
        put(atp_pkg::ADDR_INCR, 32'h100);
        repeat (8) @(negedge clk);
        chk("smoothed", 32'h1, {31'h0, cmd[31:0] - p - 32'h100 < 32'h100 && cmd[31:0] != p + 32'h100});
        put(atp_pkg::ADDR_SMOOTH, 32'h0);
        put(atp_pkg::ADDR_MODE, 32'h0);
    endtask : s_halt_jog
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        s_move();
        s_halt_jog();
        tally_and_finish();
    end
endmodule : testbench

// file: hdl/atp_axis.sv
// one axis: profile generator with smoothing and velocity averaging
`timescale 1ns/1ps
module atp_axis #(
    parameter int POS_W    = atp_pkg::POS_W,
    parameter int VEL_W    = atp_pkg::VEL_W,
    parameter int FRAC_W   = atp_pkg::FRAC_W,
    parameter int AVG_LOG2 = atp_pkg::AVG_LOG2
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // pacing
    input  wire logic                    tick,
    // settings
    input  wire logic                    jog_mode,
    input  wire logic signed [POS_W-1:0] absolute_target,
    input  wire logic [VEL_W-1:0]        slew_speed,
    input  wire logic [VEL_W-1:0]        accel_rate,
    input  wire logic [VEL_W-1:0]        decel_rate,
    input  wire logic signed [VEL_W-1:0] jog_speed,
    input  wire logic [3:0]              smoothing_time_constant,
    // commands
    input  wire logic                    begin_motion,
    input  wire logic                    halt_motion,
    input  wire logic                    retarget,
    input  wire logic                    jog_nudge,
    input  wire logic signed [POS_W-1:0] position_increment,
    input  wire logic signed [POS_W-1:0] actual_position,
    // results
    output logic signed [POS_W-1:0]      commanded_position,
    output logic signed [POS_W-1:0]      destination,
    output logic signed [VEL_W-1:0]      averaged_velocity,
    output logic                         moving,
    output logic                         in_position
);
    initial begin
        if (VEL_W + FRAC_W > POS_W + FRAC_W || AVG_LOG2 < 1 || AVG_LOG2 > 12) begin
            $error("atp_axis: unsupported widths");
        end
    end
    localparam int PW = POS_W + FRAC_W;

    logic signed [PW-1:0]    pos_reg, pos_next;
    logic signed [VEL_W:0]   vel_reg, vel_next;
    logic signed [POS_W-1:0] dest_reg, dest_next;
    logic                    run_reg, run_next;
    logic                    stop_reg, stop_next;
    logic signed [POS_W-1:0] smooth_reg, smooth_next;
    logic signed [POS_W+AVG_LOG2:0] vsum_reg, vsum_next;
    logic [AVG_LOG2-1:0]     vcnt_reg, vcnt_next;
    logic signed [VEL_W-1:0] vavg_reg, vavg_next;
    logic signed [POS_W-1:0] last_act_reg, last_act_next;

    logic signed [VEL_W:0]   target_v, acc, dec, mag;
    logic signed [PW+1:0]    remain, brake;
    logic signed [POS_W-1:0] step, dpos;
    logic                    fwd;

    always_comb begin
        pos_next      = pos_reg;
        vel_next      = vel_reg;
        dest_next     = dest_reg;
        run_next      = run_reg;
        stop_next     = stop_reg;
        smooth_next   = smooth_reg;
        vsum_next     = vsum_reg;
        vcnt_next     = vcnt_reg;
        vavg_next     = vavg_reg;
        last_act_next = last_act_reg;
        acc    = $signed({1'b0, accel_rate});
        dec    = $signed({1'b0, decel_rate});
        fwd    = (dest_reg >= commanded_position);
        remain = (PW + 2)'($signed({dest_reg, {FRAC_W{1'b0}}}) - $signed({pos_reg[PW-1], pos_reg}));
        if (!fwd) begin
            remain = -remain;
        end
        mag   = (vel_reg < 0) ? -vel_reg : vel_reg;
        // distance to stop from present speed, with one sample of margin
        brake = (PW + 2)'((mag * (mag + dec)) / (2 * ((dec == 0) ? 1 : dec)));
        if (jog_mode) begin
            target_v = stop_reg ? '0 : $signed({jog_speed[VEL_W-1], jog_speed});
        end else if (stop_reg || remain <= brake) begin
            target_v = '0;
        end else begin
            target_v = fwd ? $signed({1'b0, slew_speed}) : -$signed({1'b0, slew_speed});
        end
        if (begin_motion && !run_reg) begin
            run_next  = 1'b1;
            stop_next = 1'b0;
            dest_next = absolute_target;
        end
        if (retarget) begin
            dest_next = absolute_target;
            run_next  = 1'b1;
            stop_next = 1'b0;
        end
        if (halt_motion && run_reg) begin
            stop_next = 1'b1;
        end
        if (tick && run_reg) begin
            // ramp toward the target speed, never a step
            if (vel_reg < target_v) begin
                vel_next = (target_v - vel_reg > ((vel_reg < 0) ? dec : acc)) ?
                           vel_reg + ((vel_reg < 0) ? dec : acc) : target_v;
            end else if (vel_reg > target_v) begin
                vel_next = (vel_reg - target_v > ((vel_reg > 0) ? dec : acc)) ?
                           vel_reg - ((vel_reg > 0) ? dec : acc) : target_v;
            end
            pos_next = pos_reg + PW'(vel_next);
            if (!jog_mode && !stop_reg && (remain <= $signed((PW + 2)'(mag)) || remain <= 0)
                && vel_next * vel_reg <= 0 + mag * mag) begin
                if (remain <= $signed((PW + 2)'(mag + 1))) begin
                    pos_next = $signed({dest_reg, {FRAC_W{1'b0}}});
                    vel_next = '0;
                    run_next = 1'b0;
                end
            end
            if (stop_reg && vel_next == 0) begin
                run_next  = 1'b0;
                stop_next = 1'b0;
                dest_next = pos_next[PW-1:FRAC_W];
            end
            if (jog_mode && stop_reg && vel_next == 0) begin
                run_next = 1'b0;
            end
        end
        // a nudge adds to this sample's step instead of replacing it, so no motion is lost
        if (jog_nudge) begin
            pos_next = pos_next + $signed({position_increment, {FRAC_W{1'b0}}});
        end
        if (!run_next) begin
            vel_next = (jog_nudge || !tick) ? vel_next : '0;
        end
        if (tick) begin
            // first-order filter, shift sets the time constant
            step        = pos_reg[PW-1:FRAC_W] - smooth_reg;
            smooth_next = smooth_reg + (step >>> smoothing_time_constant);
            if (smoothing_time_constant == 0) begin
                smooth_next = pos_next[PW-1:FRAC_W];
            end
            dpos          = actual_position - last_act_reg;
            last_act_next = actual_position;
            vsum_next     = vsum_reg + (POS_W + AVG_LOG2 + 1)'(dpos);
            vcnt_next     = vcnt_reg + 1'b1;
            if (vcnt_reg == '1) begin
                vavg_next = VEL_W'(vsum_next >>> AVG_LOG2);
                vsum_next = '0;
            end
        end else begin
            step = '0;
            dpos = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pos_reg      <= '0;
            vel_reg      <= '0;
            dest_reg     <= '0;
            run_reg      <= 1'b0;
            stop_reg     <= 1'b0;
            smooth_reg   <= '0;
            vsum_reg     <= '0;
            vcnt_reg     <= '0;
            vavg_reg     <= '0;
            last_act_reg <= '0;
        end else begin
            pos_reg      <= pos_next;
            vel_reg      <= vel_next;
            dest_reg     <= dest_next;
            run_reg      <= run_next;
            stop_reg     <= stop_next;
            smooth_reg   <= smooth_next;
            vsum_reg     <= vsum_next;
            vcnt_reg     <= vcnt_next;
            vavg_reg     <= vavg_next;
            last_act_reg <= last_act_next;
        end
    end

    assign commanded_position = smooth_reg;
    assign destination        = run_reg ? dest_reg : smooth_reg;
    assign averaged_velocity  = vavg_reg;
    assign moving             = run_reg;
    assign in_position        = !run_reg && ((actual_position - smooth_reg) <= $signed(atp_pkg::IN_POS_TOL))
                                && ((smooth_reg - actual_position) <= $signed(atp_pkg::IN_POS_TOL));
endmodule : atp_axis

// file: hdl/axis_trajectory_profiler.sv
// top: command port, per-axis settings and the axis profilers
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
module axis_trajectory_profiler #(
    parameter int AXES  = atp_pkg::AXES,
    parameter int POS_W = atp_pkg::POS_W,
    parameter int VEL_W = atp_pkg::VEL_W
) (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    // sample period pacing
    input  wire logic                         sample_tick,
    // command port
    input  wire logic [3:0]                   addr,
    input  wire logic [31:0]                  wdata,
    input  wire logic                         wr,
    input  wire logic                         rd,
    output logic [31:0]                       rdata,
    // servo side
    input  wire logic [AXES*POS_W-1:0]        actual_position,
    output logic [AXES*POS_W-1:0]             commanded_position,
    // wait conditions
    output logic [AXES-1:0]                   wait_profiler_done,
    output logic [AXES-1:0]                   wait_in_position
);
    initial begin
        if (AXES < 1 || AXES > 4 || POS_W != 32 || VEL_W > 31) begin
            $error("axis_trajectory_profiler: unsupported parameters");
        end
    end

    // ****************************************
    // settings
    // ****************************************
    logic [1:0]              sel_reg, sel_next;
    logic [AXES-1:0]         jog_reg, jog_next;
    logic [POS_W-1:0]        tgt_reg [AXES], tgt_next [AXES];
    logic [POS_W-1:0]        rel_reg [AXES], rel_next [AXES];
    logic [VEL_W-1:0]        slew_reg [AXES], slew_next [AXES];
    logic [VEL_W-1:0]        acc_reg [AXES], acc_next [AXES];
    logic [VEL_W-1:0]        dec_reg [AXES], dec_next [AXES];
    logic [VEL_W-1:0]        jog_spd_reg [AXES], jog_spd_next [AXES];
    logic [3:0]              sm_reg [AXES], sm_next [AXES];
    logic [AXES-1:0]         rej_reg, rej_next;
    logic [31:0]             rdata_reg, rdata_next;

    logic [AXES-1:0]         go, halt, retgt, nudge, mov, inpos;
    logic signed [POS_W-1:0] cpos [AXES];
    logic signed [POS_W-1:0] dest [AXES];
    logic signed [VEL_W-1:0] avel [AXES];
    logic [AXES-1:0]         start_mask;
    logic [AXES-1:0]         axis_bit;
    logic signed [POS_W-1:0] inc_val;
    logic signed [POS_W-1:0] new_tgt;
    atp_pkg::atp_bus_t       bus;

    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
    assign inc_val = $signed(bus.wdata);

    always_comb begin
        sel_next   = sel_reg;
        jog_next   = jog_reg;
        rej_next   = rej_reg;
        go         = '0;
        halt       = '0;
        retgt      = '0;
        nudge      = '0;
        new_tgt    = '0;
        rdata_next = '0;
        axis_bit   = AXES'(1) << sel_reg;
        start_mask = (bus.wdata[AXES-1:0] == '0) ? '1 : bus.wdata[AXES-1:0];
        for (int i = 0; i < AXES; i++) begin
            tgt_next[i]     = tgt_reg[i];
            rel_next[i]     = rel_reg[i];
            slew_next[i]    = slew_reg[i];
            acc_next[i]     = acc_reg[i];
            dec_next[i]     = dec_reg[i];
            jog_spd_next[i] = jog_spd_reg[i];
            sm_next[i]      = sm_reg[i];
        end
        if (bus.wr) begin
            case (bus.addr)
                atp_pkg::ADDR_AXIS_SEL: sel_next = bus.wdata[1:0];
                atp_pkg::ADDR_MODE:     jog_next[sel_reg] = bus.wdata[0];
                atp_pkg::ADDR_TARGET_ABS: begin
                    if (mov[sel_reg]) begin
                        rej_next[sel_reg] = 1'b1;
                    end else begin
                        tgt_next[sel_reg] = bus.wdata;
                    end
                end
                atp_pkg::ADDR_TARGET_REL: begin
                    if (mov[sel_reg]) begin
                        rej_next[sel_reg] = 1'b1;
                    end else begin
                        rel_next[sel_reg] = bus.wdata;
                        tgt_next[sel_reg] = POS_W'(cpos[sel_reg] + $signed(bus.wdata));
                    end
                end
                atp_pkg::ADDR_SLEW:   slew_next[sel_reg] = bus.wdata[VEL_W-1:0];
                atp_pkg::ADDR_ACCEL:  acc_next[sel_reg]  = bus.wdata[VEL_W-1:0];
                atp_pkg::ADDR_DECEL: begin
                    if (mov[sel_reg] && !jog_reg[sel_reg]) begin
                        rej_next[sel_reg] = 1'b1;
                    end else begin
                        dec_next[sel_reg] = bus.wdata[VEL_W-1:0];
                    end
                end
                atp_pkg::ADDR_JOG:    jog_spd_next[sel_reg] = bus.wdata[VEL_W-1:0];
                atp_pkg::ADDR_SMOOTH: sm_next[sel_reg] = bus.wdata[3:0];
                atp_pkg::ADDR_BEGIN:  go = start_mask & ~mov;
                atp_pkg::ADDR_HALT:   halt = start_mask;
                atp_pkg::ADDR_INCR: begin
                    if (jog_reg[sel_reg]) begin
                        nudge = axis_bit;
                    end else if (!mov[sel_reg]) begin
                        rel_next[sel_reg] = bus.wdata;
                        new_tgt = cpos[sel_reg] + inc_val;
                        tgt_next[sel_reg] = new_tgt;
                        retgt = axis_bit;
                    end else if ((dest[sel_reg] >= cpos[sel_reg]) == (inc_val >= 0)) begin
                        new_tgt = $signed(tgt_reg[sel_reg]) + inc_val;
                        tgt_next[sel_reg] = new_tgt;
                        retgt = axis_bit;
                    end else begin
                        rej_next[sel_reg] = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (bus.rd) begin
            case (bus.addr)
                atp_pkg::ADDR_AXIS_SEL:   rdata_next = {30'h0, sel_reg};
                atp_pkg::ADDR_MODE:       rdata_next = {31'h0, jog_reg[sel_reg]};
                atp_pkg::ADDR_TARGET_ABS: rdata_next = tgt_reg[sel_reg];
                atp_pkg::ADDR_TARGET_REL: rdata_next = rel_reg[sel_reg];
                atp_pkg::ADDR_SLEW:       rdata_next = 32'(slew_reg[sel_reg]);
                atp_pkg::ADDR_ACCEL:      rdata_next = 32'(acc_reg[sel_reg]);
                atp_pkg::ADDR_DECEL:      rdata_next = 32'(dec_reg[sel_reg]);
                atp_pkg::ADDR_JOG:        rdata_next = 32'($signed(jog_spd_reg[sel_reg]));
                atp_pkg::ADDR_SMOOTH:     rdata_next = {28'h0, sm_reg[sel_reg]};
                atp_pkg::ADDR_STATUS: begin
                    rdata_next[atp_pkg::ST_MOVING]    = mov[sel_reg];
                    rdata_next[atp_pkg::ST_PROF_DONE] = !mov[sel_reg];
                    rdata_next[atp_pkg::ST_IN_POS]    = inpos[sel_reg];
                    rdata_next[atp_pkg::ST_REJECT]    = rej_reg[sel_reg];
                    // reading clears the reject flag unless a new reject lands now while the flag is clear
                    if (!(bus.wr && rej_next[sel_reg] != rej_reg[sel_reg])) begin
                        rej_next[sel_reg] = 1'b0;
                    end
                end
                atp_pkg::ADDR_DEST:       rdata_next = dest[sel_reg];
                atp_pkg::ADDR_AVG_VEL:    rdata_next = 32'(avel[sel_reg]);
                atp_pkg::ADDR_CMD_POS:    rdata_next = cpos[sel_reg];
                default:                  rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sel_reg   <= '0;
            jog_reg   <= '0;
            rej_reg   <= '0;
            rdata_reg <= '0;
            for (int i = 0; i < AXES; i++) begin
                tgt_reg[i]     <= '0;
                rel_reg[i]     <= '0;
                slew_reg[i]    <= atp_pkg::RST_SLEW;
                acc_reg[i]     <= atp_pkg::RST_ACCEL;
                dec_reg[i]     <= atp_pkg::RST_DECEL;
                jog_spd_reg[i] <= '0;
                sm_reg[i]      <= atp_pkg::RST_SMOOTH;
            end
        end else begin
            sel_reg   <= sel_next;
            jog_reg   <= jog_next;
            rej_reg   <= rej_next;
            rdata_reg <= rdata_next;
            for (int i = 0; i < AXES; i++) begin
                tgt_reg[i]     <= tgt_next[i];
                rel_reg[i]     <= rel_next[i];
                slew_reg[i]    <= slew_next[i];
                acc_reg[i]     <= acc_next[i];
                dec_reg[i]     <= dec_next[i];
                jog_spd_reg[i] <= jog_spd_next[i];
                sm_reg[i]      <= sm_next[i];
            end
        end
    end

    // ****************************************
    // axis profilers
    // ****************************************
    for (genvar g = 0; g < AXES; g++) begin : g_axis
        atp_axis u_axis (
            .clk                     (clk),
            .rst_n                   (rst_n),
            .tick                    (sample_tick),
            .jog_mode                (jog_reg[g]),
            .absolute_target         ($signed(tgt_next[g])),
            .slew_speed              (slew_reg[g]),
            .accel_rate              (acc_reg[g]),
            .decel_rate              (dec_reg[g]),
            .jog_speed               ($signed(jog_spd_reg[g])),
            .smoothing_time_constant (sm_reg[g]),
            .begin_motion            (go[g]),
            .halt_motion             (halt[g]),
            .retarget                (retgt[g]),
            .jog_nudge               (nudge[g]),
            .position_increment      (inc_val),
            .actual_position         ($signed(actual_position[g*POS_W +: POS_W])),
            .commanded_position      (cpos[g]),
            .destination             (dest[g]),
            .averaged_velocity       (avel[g]),
            .moving                  (mov[g]),
            .in_position             (inpos[g])
        );
        assign commanded_position[g*POS_W +: POS_W] = cpos[g];
    end

    assign rdata              = rdata_reg;
    assign wait_profiler_done = ~mov;
    assign wait_in_position   = inpos;
endmodule : axis_trajectory_profiler

// file: pkg/atp_pkg.sv
// package: constants and carriers for the axis trajectory profiler
package atp_pkg;
    // ****************************************
    // widths
    // ****************************************
    localparam int POS_W  = 32;
    localparam int VEL_W  = 24;
    localparam int FRAC_W = 8;
    localparam int AXES   = 4;
    // ****************************************
    // command port
    // ****************************************
    localparam logic [3:0] ADDR_TARGET_ABS = 4'h0;
    localparam logic [3:0] ADDR_TARGET_REL = 4'h1;
    localparam logic [3:0] ADDR_SLEW       = 4'h2;
    localparam logic [3:0] ADDR_ACCEL      = 4'h3;
    localparam logic [3:0] ADDR_DECEL      = 4'h4;
    localparam logic [3:0] ADDR_JOG        = 4'h5;
    localparam logic [3:0] ADDR_MODE       = 4'h6;
    localparam logic [3:0] ADDR_BEGIN      = 4'h7;
    localparam logic [3:0] ADDR_HALT       = 4'h8;
    localparam logic [3:0] ADDR_INCR       = 4'h9;
    localparam logic [3:0] ADDR_SMOOTH     = 4'ha;
    localparam logic [3:0] ADDR_STATUS     = 4'hb;
    localparam logic [3:0] ADDR_DEST       = 4'hc;
    localparam logic [3:0] ADDR_AVG_VEL    = 4'hd;
    localparam logic [3:0] ADDR_CMD_POS    = 4'he;
    localparam logic [3:0] ADDR_AXIS_SEL   = 4'hf;
    // status bit positions
    localparam int ST_MOVING      = 0;
    localparam int ST_PROF_DONE   = 1;
    localparam int ST_IN_POS      = 2;
    localparam int ST_REJECT      = 3;
    // ****************************************
    // reset values, in-position tolerance and averaging window
    // ****************************************
    localparam logic [VEL_W-1:0] RST_SLEW   = 24'h001000;
    localparam logic [VEL_W-1:0] RST_ACCEL  = 24'h000100;
    localparam logic [VEL_W-1:0] RST_DECEL  = 24'h000100;
    localparam logic [3:0]       RST_SMOOTH = 4'h0;
    localparam logic [POS_W-1:0] IN_POS_TOL = 32'h00000002;
    localparam int AVG_LOG2 = 8;

    typedef struct packed {
        logic [3:0]       addr;
        logic [31:0]      wdata;
        logic             wr;
        logic             rd;
    } atp_bus_t;
endpackage : atp_pkg
